// [link_retry_sequence_control.sv]
// Retry layer: sequence checking, retry buffers, resend, stall and idle frames
`timescale 1ns/100ps
`default_nettype none
module link_retry_sequence_control
  import link_retry_pkg::*;
#(
  parameter int          BUF_DEPTH = 16,
  parameter logic [31:0] IDLE_POLY = 32'h8020_0003
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              coldReset,
  input  wire logic              warmReset,
  input  wire logic              remoteFlush,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxValid,
  input  wire rx_word_t          rxWord,
  input  wire logic              extNackRequest,
  output logic                   rxAccept,
  output logic                   rxSeqError,
  output logic                   ackRequest,
  output logic                   nackRequest,
  output logic [SEQ_W:0]         rxSeqField,
  input  wire logic              txInValid,
  input  wire logic [1:0]        txInClass,
  input  wire logic [WORD_W-1:0] txInData,
  output logic                   txInReady,
  output logic                   txOutValid,
  input  wire logic              txOutReady,
  output tx_word_t               txOutWord
);
  // Depth clamped so all classes together hold fewer than 128 items
  localparam int DEPTH = (CLASS_N * BUF_DEPTH < SEQ_SPAN) ? BUF_DEPTH : (SEQ_SPAN - 1) / CLASS_N;
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WORD_W-1:0] bufData [CLASS_N][DEPTH];
  logic [SEQ_W-1:0]  bufSeq  [CLASS_N][DEPTH];
  logic [PTR_W-1:0]  head_r       [CLASS_N];
  logic [PTR_W-1:0]  tail_r       [CLASS_N];
  logic [CNT_W-1:0]  count_r      [CLASS_N];
  logic [CNT_W-1:0]  resendLeft_r [CLASS_N];
  logic [CLASS_N-1:0] full;
  logic [CLASS_N-1:0] pop;
  logic [CLASS_N-1:0] resendPend;
  logic              anyFull;
  logic              allFull;
  logic              anyPop;
  logic              anyResend;
  logic              purgeDone;
  logic              clearAll;

  logic [SEQ_W-1:0]  rxCount_r;
  logic              rxPol_r;
  err_state_t        errState_r;
  logic [SEQ_W-1:0]  txCount_r;
  logic              txPol_r;
  tx_state_t         txState_r;
  logic [SEQ_W-1:0]  ackSeq_r;
  logic              ackValid_r;
  logic              stallSent_r;
  logic [CTRL_IDLE_LEN_W-1:0] idleLeft_r;
  logic [31:0]       lfsr_r;
  logic [31:0]       seed_r;
  logic [RETRY_CNT_W-1:0] retryCount_r;
  logic [31:0]       ctrl_r;
  logic [31:0]       prdata_r;

  logic              txEnable;
  logic [CTRL_IDLE_LEN_W-1:0] idleLen;
  logic              outFree;
  logic              selValid;
  tx_word_t          selWord;
  logic              takeNew;
  logic              takeResend;
  logic              startIdle;
  logic              sendIdleData;
  logic              sendStall;
  logic [1:0]        rCls;
  logic [PTR_W-1:0]  rIdx;
  logic [SEQ_W-1:0]  nextSeq;

  logic              rxChecked;
  logic              rxIsIdle;
  logic              rxPolMatch;
  logic              rxOk;
  logic              rxSeqErr;
  logic              rxIncr;
  logic              rxAckReq;
  logic              rxNackReq;
  logic              rxAckOk;
  logic              rxNackOk;

  function automatic logic [PTR_W-1:0] ptrAdd(input logic [PTR_W-1:0] p,
                                               input logic [CNT_W-1:0] n);
    logic [PTR_W+CNT_W-1:0] s;
    s = {{CNT_W{1'b0}}, p} + {{PTR_W{1'b0}}, n};
    if (s >= (PTR_W+CNT_W)'(DEPTH)) begin
      s = s - (PTR_W+CNT_W)'(DEPTH);
    end
    return s[PTR_W-1:0];
  endfunction

  // Entry is at or before the acknowledged value, measured back from tx counter
  function automatic logic isAcked(input logic [SEQ_W-1:0] e,
                                   input logic [SEQ_W-1:0] a,
                                   input logic [SEQ_W-1:0] t);
    logic [SEQ_W-1:0] de;
    logic [SEQ_W-1:0] da;
    de = t - e;
    da = t - a;
    return de >= da;
  endfunction

  function automatic logic [31:0] prbsNext(input logic [31:0] x);
    logic [31:0] v;
    v = x;
    for (int i = 0; i < 32; i++) begin
      v = v[0] ? ((v >> 1) ^ IDLE_POLY) : (v >> 1);
    end
    return v;
  endfunction

  function automatic word_kind_t classKind(input logic [1:0] c);
    word_kind_t k;
    k = KIND_DATA_END;
    if (c == CLS_BCAST) begin
      k = KIND_BCAST_END;
    end else if (c == CLS_FLOW) begin
      k = KIND_FLOW_CREDIT;
    end
    return k;
  endfunction

  assign clearAll  = rst || coldReset || remoteFlush;
  assign txEnable  = ctrl_r[CTRL_TX_ENABLE_BIT];
  assign idleLen   = ctrl_r[CTRL_IDLE_LEN_LSB +: CTRL_IDLE_LEN_W];
  assign outFree   = !txOutValid || txOutReady;
  assign nextSeq   = txCount_r + 7'h1;

  // Receive sequence check
  assign rxChecked  = rxValid && rxWord.crcOk &&
                      rxWord.kind inside {KIND_DATA_END, KIND_BCAST_END, KIND_IDLE_START,
                                          KIND_FLOW_CREDIT, KIND_STALL};
  assign rxIsIdle   = rxWord.kind == KIND_IDLE_START;
  assign rxPolMatch = rxWord.pol == rxPol_r;
  assign rxOk       = rxPolMatch && (rxIsIdle ? (rxWord.count == rxCount_r)
                                              : (rxWord.count == rxCount_r + 7'h1));
  assign rxSeqErr   = rxChecked && !rxOk;
  assign rxIncr     = rxChecked && rxOk && !rxIsIdle && rxWord.kind != KIND_STALL;
  assign rxAckReq   = rxChecked && rxOk && !rxIsIdle;
  assign rxNackReq  = rxSeqErr || extNackRequest;
  assign rxAckOk    = rxValid && rxWord.crcOk && rxWord.kind == KIND_ACK && rxWord.pol == txPol_r;
  assign rxNackOk   = rxValid && rxWord.crcOk && rxWord.kind == KIND_NACK &&
                      rxWord.pol == txPol_r;

  always_ff @(posedge clk) begin
    if (clearAll) begin
      rxCount_r  <= '0;
      rxPol_r    <= 1'b0;
      errState_r <= ERR_VALID;
    end else begin
      if (rxIncr) begin
        rxCount_r <= rxCount_r + 7'h1;
      end
      if (warmReset) begin
        errState_r <= ERR_VALID;
      end else begin
        unique case (errState_r)
          ERR_VALID: if (rxNackReq) begin
            rxPol_r    <= ~rxPol_r;
            errState_r <= ERR_ERROR;
          end
          ERR_ERROR: begin
            if (rxSeqErr && rxPolMatch) begin
              rxPol_r <= ~rxPol_r;
            end
            if (rxAckReq) begin
              errState_r <= ERR_VALID;
            end
          end
          default: errState_r <= ERR_VALID;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxAccept    <= 1'b0;
      rxSeqError  <= 1'b0;
      ackRequest  <= 1'b0;
      nackRequest <= 1'b0;
    end else begin
      rxAccept    <= rxChecked && rxOk;
      rxSeqError  <= rxSeqErr;
      ackRequest  <= rxAckReq;
      nackRequest <= rxNackReq && !rxAckReq;
    end
  end

  assign rxSeqField = {rxPol_r, rxCount_r};

  // Retry buffer status
  always_comb begin
    anyPop    = 1'b0;
    anyResend = 1'b0;
    rCls      = CLS_DATA;
    for (int c = 0; c < CLASS_N; c++) begin
      full[c]       = count_r[c] == CNT_W'(DEPTH);
      resendPend[c] = resendLeft_r[c] != '0;
      pop[c]        = ackValid_r && count_r[c] != '0 &&
                      (txState_r == TX_PURGE || count_r[c] > resendLeft_r[c]) &&
                      isAcked(bufSeq[c][head_r[c]], ackSeq_r, txCount_r);
      anyPop        = anyPop || pop[c];
      anyResend     = anyResend || resendPend[c];
    end
    for (int c = CLASS_N - 1; c >= 0; c--) begin
      if (resendPend[c]) begin
        rCls = 2'(c);
      end
    end
    anyFull = |full;
    allFull = &full;
  end

  assign rIdx      = ptrAdd(head_r[rCls], count_r[rCls] - resendLeft_r[rCls]);
  assign purgeDone = txState_r == TX_PURGE && !anyPop;

  // Transmit selection
  always_comb begin
    selWord      = '0;
    takeResend   = 1'b0;
    startIdle    = 1'b0;
    sendIdleData = 1'b0;
    sendStall    = 1'b0;
    takeNew      = 1'b0;
    selWord.pol  = txPol_r;
    selWord.count = nextSeq;
    if (outFree && txEnable && txState_r == TX_IDLE && !allFull) begin
      sendIdleData = 1'b1;
      selWord.kind = KIND_IDLE_DATA;
      selWord.data = lfsr_r;
    end else if (outFree && txEnable && txState_r != TX_PURGE) begin
      if (allFull) begin
        sendStall    = 1'b1;
        selWord.kind = KIND_STALL;
      end else if (anyResend) begin
        takeResend   = 1'b1;
        selWord.kind = classKind(rCls);
        selWord.late = rCls == CLS_BCAST;
        selWord.data = bufData[rCls][rIdx];
      end else if (anyFull && !stallSent_r) begin
        sendStall    = 1'b1;
        selWord.kind = KIND_STALL;
      end else if (txInValid && !full[txInClass]) begin
        takeNew      = 1'b1;
        selWord.kind = classKind(txInClass);
        selWord.data = txInData;
      end else begin
        startIdle     = 1'b1;
        selWord.kind  = KIND_IDLE_START;
        selWord.count = txCount_r;
      end
    end
    selValid = takeResend || sendIdleData || sendStall || takeNew || startIdle;
  end

  assign txInReady = outFree && txEnable && txState_r == TX_RUN && !allFull && !anyResend &&
                     !(anyFull && !stallSent_r) && !full[txInClass];

  always_ff @(posedge clk) begin
    if (rst) begin
      txOutValid <= 1'b0;
      txOutWord  <= '0;
    end else if (outFree) begin
      txOutValid <= selValid;
      txOutWord  <= selWord;
    end
  end

  // Retry buffer storage
  always_ff @(posedge clk) begin
    for (int c = 0; c < CLASS_N; c++) begin
      if (takeNew && txInClass == 2'(c)) begin
        bufData[c][tail_r[c]] <= txInData;
        bufSeq[c][tail_r[c]]  <= nextSeq;
      end
      if (takeResend && rCls == 2'(c)) begin
        bufSeq[c][rIdx] <= nextSeq;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clearAll) begin
      for (int c = 0; c < CLASS_N; c++) begin
        head_r[c]       <= '0;
        tail_r[c]       <= '0;
        count_r[c]      <= '0;
        resendLeft_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CLASS_N; c++) begin
        if (takeNew && txInClass == 2'(c)) begin
          tail_r[c] <= ptrAdd(tail_r[c], CNT_W'(1));
        end
        if (pop[c]) begin
          head_r[c] <= ptrAdd(head_r[c], CNT_W'(1));
        end
        count_r[c] <= count_r[c] + CNT_W'(takeNew && txInClass == 2'(c)) - CNT_W'(pop[c]);
        if (purgeDone) begin
          resendLeft_r[c] <= count_r[c];
        end else if (takeResend && rCls == 2'(c)) begin
          resendLeft_r[c] <= resendLeft_r[c] - CNT_W'(1);
        end
      end
    end
  end

  // Transmit sequencer, counter and idle generator
  always_ff @(posedge clk) begin
    if (clearAll) begin
      txCount_r    <= '0;
      txPol_r      <= 1'b0;
      txState_r    <= TX_RUN;
      ackSeq_r     <= '0;
      ackValid_r   <= 1'b0;
      stallSent_r  <= 1'b0;
      idleLeft_r   <= '0;
      lfsr_r       <= SEED_RESET;
      seed_r       <= SEED_RESET;
      retryCount_r <= '0;
    end else begin
      if (takeNew || takeResend) begin
        txCount_r <= nextSeq;
      end
      if (sendStall) begin
        stallSent_r <= 1'b1;
      end else if (takeNew || takeResend) begin
        stallSent_r <= 1'b0;
      end
      unique case (txState_r)
        TX_RUN: if (startIdle && idleLen != '0) begin
          lfsr_r     <= seed_r;
          idleLeft_r <= idleLen;
          txState_r  <= TX_IDLE;
        end
        TX_IDLE: if (allFull || warmReset) begin
          txState_r <= TX_RUN;
        end else if (sendIdleData) begin
          lfsr_r     <= prbsNext(lfsr_r);
          idleLeft_r <= idleLeft_r - 4'h1;
          if (idleLeft_r == 4'h1) begin
            seed_r    <= prbsNext(lfsr_r);
            txState_r <= TX_RUN;
          end
        end
        TX_PURGE: if (purgeDone) begin
          txCount_r  <= ackSeq_r;
          txPol_r    <= ~txPol_r;
          ackValid_r <= 1'b0;
          txState_r  <= TX_RUN;
        end
        default: txState_r <= TX_RUN;
      endcase
      if (rxNackOk && txState_r != TX_PURGE) begin
        ackSeq_r     <= rxWord.count;
        ackValid_r   <= 1'b1;
        txState_r    <= TX_PURGE;
        retryCount_r <= retryCount_r + 16'h1;
      end else if (rxAckOk && txState_r != TX_PURGE) begin
        ackSeq_r   <= rxWord.count;
        ackValid_r <= 1'b1;
      end
    end
  end

  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = psel && penable &&
                   !(paddr inside {CTRL_OFFSET, RETRY_COUNT_OFFSET, SEQ_STATUS_OFFSET,
                                   BUF_STATUS_OFFSET, SEED_OFFSET});

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == CTRL_OFFSET) begin
      ctrl_r <= pwdata & 32'h0000_00F1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r <= '0;
    end else if (psel && !penable) begin
      prdata_r <= '0;
      unique case (paddr)
        CTRL_OFFSET: prdata_r <= ctrl_r;
        RETRY_COUNT_OFFSET: prdata_r <= {16'h0000, retryCount_r};
        SEQ_STATUS_OFFSET: begin
          prdata_r[SEQ_W-1:0] <= rxCount_r;
          prdata_r[SEQ_RX_POL_BIT] <= rxPol_r;
          prdata_r[SEQ_TX_COUNT_LSB +: SEQ_W] <= txCount_r;
          prdata_r[SEQ_TX_POL_BIT] <= txPol_r;
          prdata_r[SEQ_ERR_STATE_BIT] <= errState_r == ERR_ERROR;
        end
        BUF_STATUS_OFFSET: begin
          prdata_r[7:0] <= 8'(count_r[CLS_BCAST]);
          prdata_r[15:8] <= 8'(count_r[CLS_FLOW]);
          prdata_r[23:16] <= 8'(count_r[CLS_DATA]);
          prdata_r[BUF_FULL_LSB +: CLASS_N] <= full;
        end
        SEED_OFFSET: prdata_r <= seed_r;
        default: prdata_r <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// [link_retry_pkg.sv]
// Shared types and constants for the link retry sequence control block
`default_nettype none
package link_retry_pkg;
  localparam int SEQ_W      = 7;
  localparam int WORD_W     = 32;
  localparam int CLASS_N    = 3;
  localparam int SEQ_SPAN   = 128;
  localparam int RETRY_CNT_W = 16;

  typedef enum logic [2:0] {
    KIND_DATA_END    = 3'h0,
    KIND_BCAST_END   = 3'h1,
    KIND_IDLE_START  = 3'h2,
    KIND_IDLE_DATA   = 3'h3,
    KIND_FLOW_CREDIT = 3'h4,
    KIND_STALL       = 3'h5,
    KIND_ACK         = 3'h6,
    KIND_NACK        = 3'h7
  } word_kind_t;

  typedef struct packed {
    word_kind_t         kind;
    logic               crcOk;
    logic               pol;
    logic [SEQ_W-1:0]   count;
  } rx_word_t;

  typedef struct packed {
    word_kind_t         kind;
    logic               late;
    logic               pol;
    logic [SEQ_W-1:0]   count;
    logic [WORD_W-1:0]  data;
  } tx_word_t;

  typedef enum logic [2:0] {
    TX_RUN   = 3'b001,
    TX_IDLE  = 3'b010,
    TX_PURGE = 3'b100
  } tx_state_t;

  typedef enum logic [1:0] {
    ERR_VALID = 2'b01,
    ERR_ERROR = 2'b10
  } err_state_t;

  // Retry buffer classes, in resend priority order
  localparam logic [1:0] CLS_BCAST = 2'h0;
  localparam logic [1:0] CLS_FLOW  = 2'h1;
  localparam logic [1:0] CLS_DATA  = 2'h2;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET        = 12'h000;
  localparam logic [11:0] RETRY_COUNT_OFFSET = 12'h004;
  localparam logic [11:0] SEQ_STATUS_OFFSET  = 12'h008;
  localparam logic [11:0] BUF_STATUS_OFFSET  = 12'h00C;
  localparam logic [11:0] SEED_OFFSET        = 12'h010;

  // Field positions and reset values
  localparam int CTRL_TX_ENABLE_BIT = 0;
  localparam int CTRL_IDLE_LEN_LSB  = 4;
  localparam int CTRL_IDLE_LEN_W    = 4;
  localparam int SEQ_RX_POL_BIT     = 7;
  localparam int SEQ_TX_COUNT_LSB   = 8;
  localparam int SEQ_TX_POL_BIT     = 15;
  localparam int SEQ_ERR_STATE_BIT  = 16;
  localparam int BUF_FULL_LSB       = 24;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0041;
  localparam logic [31:0] SEED_RESET = 32'hFFFF_FFFF;
endpackage
`default_nettype wire

// [link_retry_asserts.sv]
// Checker for receive sequence and transmit issue rules
`timescale 1ns/100ps
`default_nettype none
module link_retry_asserts
  import link_retry_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst,
  input wire logic           coldReset,
  input wire logic           warmReset,
  input wire logic           remoteFlush,
  input wire logic           rxValid,
  input wire rx_word_t       rxWord,
  input wire logic           extNackRequest,
  input wire logic           rxAccept,
  input wire logic           rxSeqError,
  input wire logic           ackRequest,
  input wire logic [SEQ_W:0] rxSeqField,
  input wire logic           txInValid,
  input wire logic           txInReady,
  input wire logic           txOutValid,
  input wire tx_word_t       txOutWord
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic quiet, live, frameEnd, polOk, plusOne;
  assign quiet = !coldReset && !remoteFlush && !warmReset && !extNackRequest;
  assign live = rxValid && rxWord.crcOk && quiet;
  assign frameEnd = rxWord.kind inside {KIND_DATA_END, KIND_BCAST_END, KIND_FLOW_CREDIT};
  assign polOk = rxWord.pol == rxSeqField[SEQ_W];
  assign plusOne = rxWord.count == rxSeqField[SEQ_W-1:0] + 7'h1;
  sequence good_end_s;
    live && frameEnd && polOk && plusOne;
  endsequence
  sequence bad_count_s;
    live && frameEnd && polOk && !plusOne;
  endsequence
  accept_next_a: assert property (good_end_s |=> rxAccept && ackRequest && !rxSeqError)
    else $error("end word refused");
  count_step_a: assert property (good_end_s |=> rxSeqField[6:0] == $past(rxSeqField[6:0]) + 7'h1)
    else $error("counter not stepped");
  reject_hold_a: assert property (bad_count_s |=> rxSeqError && !rxAccept && $stable(rxSeqField[6:0]))
    else $error("bad count kept");
  pol_flip_a: assert property (bad_count_s |=> rxSeqField[7] != $past(rxSeqField[7]))
    else $error("polarity kept");
  pol_reject_a: assert property (live && !polOk &&
    (frameEnd || rxWord.kind == KIND_IDLE_START) |=> !rxAccept && rxSeqError)
    else $error("bad polarity taken");
  idle_exact_a: assert property (live && rxWord.kind == KIND_IDLE_START &&
    polOk && rxWord.count == rxSeqField[6:0] |=> rxAccept && !ackRequest ##0 $stable(rxSeqField))
    else $error("idle start misjudged");
  crc_skip_a: assert property (rxValid && !rxWord.crcOk |=> !rxAccept && !rxSeqError)
    else $error("bad crc checked");
  flush_clear_a: assert property (coldReset || remoteFlush |=> rxSeqField == 8'h00)
    else $error("state not cleared");
  warm_keep_a: assert property (warmReset && !coldReset && !remoteFlush && !rxValid &&
    !extNackRequest |=> $stable(rxSeqField))
    else $error("warm reset changed state");
  tx_issue_a: assert property (txInValid && txInReady && quiet |=> txOutValid &&
    txOutWord.kind inside {KIND_DATA_END, KIND_BCAST_END, KIND_FLOW_CREDIT})
    else $error("item not issued");
endmodule
bind link_retry_sequence_control link_retry_asserts chk_u (.*);
`default_nettype wire

// [lane_side_model.sv]
// Lane side model: random-stall sink and receive word source
`timescale 1ns/100ps
`default_nettype none
module lane_side_model
  import link_retry_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     stallOn,
  input  wire logic     txOutValid,
  input  wire tx_word_t txOutWord,
  output logic          txOutReady,
  output logic          rxValid,
  output rx_word_t      rxWord,
  output logic          gotValid,
  output tx_word_t      gotWord
);
  int seed = 31;
  initial begin
    txOutReady = 1'b1;
    rxValid = 1'b0;
    rxWord = '0;
    gotValid = 1'b0;
    gotWord = '0;
  end
  always @(posedge clk) begin
    txOutReady <= !stallOn || ($random(seed) & 1) == 1;
    gotValid <= txOutValid && txOutReady;
    gotWord <= txOutWord;
  end
  // One word for one cycle, then the bus shows a changed pattern
  task automatic sendRx(input word_kind_t k, input logic c, input logic p, input logic [6:0] n);
    @(posedge clk);
    rxValid <= 1'b1;
    rxWord <= '{kind: k, crcOk: c, pol: p, count: n};
    @(posedge clk);
    rxValid <= 1'b0;
    rxWord <= rx_word_t'(~rxWord);
  endtask
endmodule
`default_nettype wire

// [link_retry_sequence_control_tb.sv]
// Self-checking bench for the retry sequence control block
`timescale 1ns/100ps
`default_nettype none
module link_retry_sequence_control_tb;
  import link_retry_pkg::*;
  localparam int DEPTH = 4;
  logic           clk = 0, rst = 1, coldReset = 0, warmReset = 0, remoteFlush = 0, stallOn = 0;
  logic           psel = 0, penable = 0, pwrite = 0, extNackRequest = 0, txInValid = 0, e;
  logic           pready, pslverr, rxValid, rxAccept, rxSeqError, ackRequest, nackRequest;
  logic           txInReady, txOutValid, txOutReady, gotValid;
  logic [11:0]    paddr = '0;
  logic [31:0]    pwdata = '0, txInData = '0, prdata, q;
  logic [SEQ_W:0] rxSeqField;
  logic [1:0]     txInClass = '0;
  rx_word_t       rxWord;
  tx_word_t       txOutWord, gotWord, w, expQ[$], bufQ[3][$];
  int             bad_count = 0, num_checks = 0, seed = 31, r, tgt;
  int             rxCnt, rxPol, errSt, txCnt, txPol, retries, lastCnt, lastPol, stalls, seedChk;
  word_kind_t     k, kinds[5] = '{KIND_DATA_END, KIND_BCAST_END, KIND_IDLE_START,
                                  KIND_FLOW_CREDIT, KIND_STALL};
  logic [1:0]     order[6] = '{CLS_DATA, CLS_FLOW, CLS_DATA, CLS_BCAST, CLS_DATA, CLS_BCAST};
  link_retry_sequence_control #(.BUF_DEPTH(DEPTH)) dut_u (.*);
  lane_side_model lane_u (.*);
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) bad_count++;
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check("register", {a, q}, {a, want});
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {extNackRequest, warmReset, remoteFlush, coldReset} <= m;
    @(posedge clk);
    {extNackRequest, warmReset, remoteFlush, coldReset} <= 4'h0;
    #1;
  endtask
  task automatic resetModel();
    {rxCnt, rxPol, errSt, txCnt, txPol, retries, lastCnt, lastPol, stalls} = '0;
    seedChk = 1;
    expQ.delete();
    foreach (bufQ[c]) bufQ[c].delete();
  endtask
  task automatic rx(input word_kind_t kd, input logic c, input logic p, input logic [6:0] n);
    logic acc, err, ackR;
    acc = c && p == rxPol[0] && n == (kd == KIND_IDLE_START ? rxCnt : (rxCnt + 1) % 128);
    err = c && !acc;
    ackR = acc && kd != KIND_IDLE_START;
    lane_u.sendRx(kd, c, p, n);
    #1;
    check("rxAccept", rxAccept, acc);
    check("rxSeqError", rxSeqError, err);
    check("ackRequest", ackRequest, ackR);
    check("nackRequest", nackRequest, err);
    if (ackR && kd != KIND_STALL) rxCnt = (rxCnt + 1) % 128;
    if (errSt == 0 && err) {rxPol, errSt} = {~rxPol, 32'h1};
    else if (errSt == 1 && ackR) errSt = 0;
    else if (errSt == 1 && err && p == rxPol[0]) rxPol = ~rxPol;
    check("rxSeqField", rxSeqField, {rxPol[0], rxCnt[6:0]});
  endtask
  task automatic send(input logic [1:0] cls, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    txInValid <= 1'b1;
    txInClass <= cls;
    txInData <= d;
    do begin
      @(posedge clk);
      n++;
    end while (txInReady !== 1'b1 && n < 200);
    txInValid <= 1'b0;
    txCnt = (txCnt + 1) % 128;
    w = '{kind: cls == CLS_BCAST ? KIND_BCAST_END : cls == CLS_FLOW ? KIND_FLOW_CREDIT :
          KIND_DATA_END, late: 1'b0, pol: txPol[0], count: txCnt[6:0], data: d};
    expQ.push_back(w);
    bufQ[cls].push_back(w);
  endtask
  task automatic ackNack(input logic nack, input logic p, input logic [6:0] n);
    lane_u.sendRx(nack ? KIND_NACK : KIND_ACK, 1'b1, p, n);
    if (p != txPol[0]) return;
    for (int c = 0; c < 3; c++)
      while (bufQ[c].size() > 0 && ((n - bufQ[c][0].count) & 7'h7F) < 64) void'(bufQ[c].pop_front());
    if (!nack) return;
    retries++;
    txCnt = n;
    txPol = ~txPol;
    for (int c = 0; c < 3; c++)
      foreach (bufQ[c][i]) begin
        txCnt = (txCnt + 1) % 128;
        {bufQ[c][i].count, bufQ[c][i].pol, bufQ[c][i].late} = {txCnt[6:0], txPol[0], c == 0};
        expQ.push_back(bufQ[c][i]);
      end
  endtask
  function automatic logic [31:0] bufStat();
    logic [31:0] s;
    s = '0;
    for (int c = 0; c < 3; c++) s[c*8 +: 8] = bufQ[c].size();
    for (int c = 0; c < 3; c++) s[BUF_FULL_LSB + c] = bufQ[c].size() == DEPTH;
    return s;
  endfunction
  task automatic drain();
    for (int n = 0; n < 300 && expQ.size() > 0; n++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk)
    if (gotValid === 1'b1)
      case (gotWord.kind)
        KIND_IDLE_START: begin
          check("idleStart", {gotWord.pol, gotWord.count}, {lastPol[0], lastCnt[6:0]});
          if (seedChk == 1) seedChk = 2;
        end
        KIND_IDLE_DATA: if (seedChk == 2) begin
          check("seed", gotWord.data, SEED_RESET);
          seedChk = 0;
        end
        KIND_STALL: begin
          stalls++;
          check("stallSeq", {gotWord.pol, gotWord.count}, {lastPol[0], lastCnt[6:0] + 7'h1});
        end
        default: begin
          w = expQ.size() > 0 ? expQ.pop_front() : '1;
          check("txOutWord", gotWord, w);
          {lastCnt, lastPol} = {25'h0, w.count, 31'h0, w.pol};
        end
      endcase
  initial begin
    resetModel();
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdChk(CTRL_OFFSET, CTRL_RESET);
    rdChk(RETRY_COUNT_OFFSET, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped", {e, q}, 33'h1_0000_0000);
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      k = kinds[r[2:0] % 5];
      tgt = k == KIND_IDLE_START ? rxCnt : (rxCnt + 1) % 128;
      rx(k, r[5:3] != 3'h0, rxPol[0] ^ (r[8:6] == 3'h0), r[11:9] == 3'h0 ? r[18:12] : tgt[6:0]);
    end
    pulse(4'h8);
    {rxPol, errSt} = {errSt == 0 ? ~rxPol : rxPol, 32'h1};
    check("rxSeqField", rxSeqField, {rxPol[0], rxCnt[6:0]});
    pulse(4'h4);
    errSt = 0;
    check("rxSeqField", rxSeqField, {rxPol[0], rxCnt[6:0]});
    rx(KIND_DATA_END, 1'b1, ~rxPol[0], rxCnt[6:0] + 7'h1);
    pulse(4'h2);
    resetModel();
    check("rxSeqField", rxSeqField, 8'h00);
    foreach (order[i]) send(order[i], $random(seed));
    drain();
    ackNack(1'b0, txPol[0], 7'h1);
    repeat (8) @(posedge clk);
    rdChk(BUF_STATUS_OFFSET, bufStat());
    ackNack(1'b1, ~txPol[0], 7'h2);
    repeat (8) @(posedge clk);
    rdChk(RETRY_COUNT_OFFSET, retries);
    ackNack(1'b1, txPol[0], 7'h2);
    drain();
    rdChk(RETRY_COUNT_OFFSET, retries);
    rdChk(BUF_STATUS_OFFSET, bufStat());
    stallOn <= 1'b1;
    repeat (2) send(CLS_DATA, $random(seed));
    drain();
    txInClass <= CLS_DATA;
    txInValid <= 1'b1;
    repeat (6) @(posedge clk);
    check("txInReady", txInReady, 1'b0);
    txInValid <= 1'b0;
    check("stallSeen", stalls > 0, 1'b1);
    ackNack(1'b0, txPol[0], txCnt[6:0]);
    repeat (8) @(posedge clk);
    rdChk(BUF_STATUS_OFFSET, bufStat());
    stallOn <= 1'b0;
    pulse(4'h4);
    rdChk(RETRY_COUNT_OFFSET, retries);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0040);
    repeat (20) @(posedge clk);
    pulse(4'h1);
    resetModel();
    check("rxSeqField", rxSeqField, 8'h00);
    rdChk(RETRY_COUNT_OFFSET, 32'h0);
    rdChk(BUF_STATUS_OFFSET, 32'h0);
    rdChk(SEED_OFFSET, SEED_RESET);
    apb(1'b1, CTRL_OFFSET, CTRL_RESET);
    repeat (30) @(posedge clk);
    check("seedSeen", seedChk, 0);
    check("pending", expQ.size(), 0);
    conclude();
  end
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
